//--- hdl/hcw_pkg.sv
// Purpose: shared constants and types for the host counters / word swap bank
// Assumes: 200 MHz device clock, byte addresses on the host bus
// Notes: offsets are byte addresses of 32-bit registers
package hcw_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned REF_HZ = 25_000_000;
  localparam int unsigned FR_DIV = CLK_HZ / REF_HZ;
  // time the free-running counter may need to clear after reset
  localparam int unsigned FREE_CLR_NS = 160;
  localparam int unsigned FREE_CLR_CYC =
    (FREE_CLR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [7:0] OFS_TMR_CFG = 8'h8C;
  localparam logic [7:0] OFS_TMR_CNT = 8'h90;
  localparam logic [7:0] OFS_SWAP = 8'h98;
  localparam logic [7:0] OFS_FREE = 8'h9C;
  localparam logic [7:0] OFS_DROP = 8'hA0;

  localparam int unsigned TMR_EN_BIT = 29;
  localparam logic [15:0] TMR_LOAD_RST = 16'hFFFF;
  localparam logic [15:0] TMR_CNT_RST = 16'hFFFF;
  localparam logic [31:0] SWAP_RST = 32'h0000_0000;
  localparam logic [31:0] SWAP_ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] DROP_RST = 32'h0000_0000;
  localparam logic [31:0] DROP_MID_PRE = 32'h7FFF_FFFF;
  localparam logic [31:0] DROP_MID = 32'h8000_0000;
  localparam logic [31:0] FREE_RST = 32'h0000_0000;

  typedef struct packed {
    logic bus16;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [31:0] data;
  } hcw_pins_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_READ = 3'b010,
    HS_WRITE = 3'b100
  } hcw_hst_t;
endpackage : hcw_pkg

//--- hdl/hcw_free_counter.sv
// Purpose: free-running 32-bit counter advancing at the reference rate
// Assumes: DIV device clocks make one reference cycle
// Notes: no power state input exists, so nothing can stop it
`timescale 1ns/1ps
`default_nettype none
module hcw_free_counter
  import hcw_pkg::*;
#(
  parameter int unsigned DIV = FR_DIV
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [31:0] count_o
);
  localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
  logic [DW-1:0] div_r;
  logic [31:0] cnt_r;
  wire tick = (div_r == DIV_LAST);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_r <= '0;
      cnt_r <= FREE_RST;
    end
    else
    begin
      div_r <= tick ? '0 : div_r + DW'(1);
      // wraps from all ones to zero on its own
      if (tick)
        cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  assign count_o = cnt_r;

  a_free_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick |=> cnt_r == $past(cnt_r) + 32'h0000_0001)
    else $error("free counter did not step on reference tick");
  a_free_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !tick |=> $stable(cnt_r))
    else $error("free counter moved between reference ticks");
  c_free_wrap: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    tick && cnt_r == 32'hFFFF_FFFF ##1 cnt_r == 32'h0000_0000);
endmodule : hcw_free_counter
`default_nettype wire

//--- hdl/hcw_bank.sv
// Purpose: host-visible timer count, word swap, free counter, drop counter
// Assumes: asynchronous SRAM-like host pins, frame events on clk_i
// Notes: host strobes pass four flops (three stages, one filter); data out is valid one clock after
//        the read is recognised and stands until the strobe is released
`timescale 1ns/1ps
`default_nettype none
module hcw_bank
  import hcw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic bus16_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic data_oe_o,
  input wire logic frame_drop_i,
  output logic drop_mid_evt_o,
  input wire logic [31:0] tx_word_i,
  input wire logic tx_word_vld_i,
  output logic tx_word_rdy_o,
  output logic [15:0] tx_half_o,
  output logic tx_half_vld_o,
  input wire logic [15:0] rx_half_i,
  input wire logic rx_half_vld_i,
  output logic [31:0] rx_word_o,
  output logic rx_word_vld_o
);
  hcw_pins_t pin_s1_r, pin_s2_r, pin_s3_r;
  logic bus16_r, cs_act_r, rd_act_r, wr_act_r;
  hcw_hst_t st_r, st_nxt;
  logic [7:0] acc_addr_r;
  logic [31:0] acc_data_r;
  logic [31:0] data_r;
  logic oe_r;
  logic [15:0] tmr_cnt_r, tmr_load_r;
  logic tmr_en_r;
  logic [31:0] swap_r;
  logic [31:0] free_cnt;
  logic [31:0] fr_snap_r, drop_snap_r, drop_r;
  logic fr_pend_r, drop_pend_r, drop_evt_r;
  logic [15:0] tx_half_r, tx_hi_r, rx_lo_r;
  logic tx_vld_r, tx_rdy_r, rx_pend_r, rx_vld_r;
  logic [31:0] rx_word_r;

  function automatic logic [31:0] merge16(input logic [31:0] old,
                                          input logic [15:0] d,
                                          input logic hi);
    merge16 = hi ? {d, old[15:0]} : {old[31:16], d};
  endfunction : merge16

  // pin synchroniser: only stage two reads stage one
  hcw_pins_t pins_in;
  assign pins_in = '{bus16: bus16_i, cs_n: cs_n_i, rd_n: rd_n_i,
                     wr_n: wr_n_i, addr: addr_i, data: data_i};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1_r <= '{bus16: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                    addr: 8'h00, data: 32'h0000_0000};
      pin_s2_r <= '{bus16: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                    addr: 8'h00, data: 32'h0000_0000};
      pin_s3_r <= '{bus16: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                    addr: 8'h00, data: 32'h0000_0000};
    end
    else
    begin
      pin_s1_r <= pins_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // a level counts once stages two and three agree
  wire bus16_ok = (pin_s2_r.bus16 == pin_s3_r.bus16);
  wire cs_ok = (pin_s2_r.cs_n == pin_s3_r.cs_n);
  wire rd_ok = (pin_s2_r.rd_n == pin_s3_r.rd_n);
  wire wr_ok = (pin_s2_r.wr_n == pin_s3_r.wr_n);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus16_r <= 1'b0;
      cs_act_r <= 1'b0;
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
    end
    else
    begin
      bus16_r <= bus16_ok ? pin_s3_r.bus16 : bus16_r;
      cs_act_r <= cs_ok ? ~pin_s3_r.cs_n : cs_act_r;
      rd_act_r <= rd_ok ? ~pin_s3_r.rd_n : rd_act_r;
      wr_act_r <= wr_ok ? ~pin_s3_r.wr_n : wr_act_r;
    end
  end

  // host access sequencing
  wire rd_on = cs_act_r & rd_act_r;
  wire wr_on = cs_act_r & wr_act_r;
  wire rd_go = (st_r == HS_IDLE) & rd_on;
  wire wr_go = (st_r == HS_WRITE) & ~wr_on;
  // stage three must still show the strobes, else the data is already gone
  wire wr_smp = wr_on & ~pin_s3_r.cs_n & ~pin_s3_r.wr_n;

  always_comb
  begin
    case (st_r)
      HS_IDLE: st_nxt = rd_on ? HS_READ : (wr_on ? HS_WRITE : HS_IDLE);
      HS_READ: st_nxt = rd_on ? HS_READ : HS_IDLE;
      HS_WRITE: st_nxt = wr_on ? HS_WRITE : HS_IDLE;
      default: st_nxt = HS_IDLE;
    endcase
  end

  // address decode; the word address uses bits above A1
  wire [7:0] cur_addr = rd_go ? pin_s3_r.addr : acc_addr_r;
  wire [7:0] word_addr = {cur_addr[7:2], 2'b00};
  wire sel_tcfg = (word_addr == OFS_TMR_CFG);
  wire sel_tcnt = (word_addr == OFS_TMR_CNT);
  wire sel_swap = (word_addr == OFS_SWAP);
  wire sel_free = (word_addr == OFS_FREE);
  wire sel_drop = (word_addr == OFS_DROP);
  wire swap_inv = (swap_r == SWAP_ALL_ONES);
  wire half_hi = swap_inv ? ~cur_addr[1] : cur_addr[1];

  // 16-bit reads of the wide counters: first half latches, second replays
  wire [31:0] fr_src = (bus16_r & fr_pend_r) ? fr_snap_r : free_cnt;
  wire [31:0] drop_src = (bus16_r & drop_pend_r) ? drop_snap_r : drop_r;
  wire [31:0] tcfg_word = {2'b00, tmr_en_r, 13'h0000, tmr_load_r};
  wire [31:0] rd_word =
    sel_tcfg ? tcfg_word :
    sel_tcnt ? {16'h0000, tmr_cnt_r} :
    sel_swap ? swap_r :
    sel_free ? fr_src :
    sel_drop ? drop_src : 32'h0000_0000;
  // swap only matters on the 16-bit bus
  wire [31:0] rd_out = bus16_r ?
    {16'h0000, (half_hi ? rd_word[31:16] : rd_word[15:0])} : rd_word;

  wire fr_first = rd_go & sel_free & bus16_r & ~fr_pend_r;
  wire fr_second = rd_go & sel_free & bus16_r & fr_pend_r;
  wire drop_first = rd_go & sel_drop & bus16_r & ~drop_pend_r;
  wire drop_second = rd_go & sel_drop & bus16_r & drop_pend_r;
  wire drop_clr = rd_go & sel_drop & (~bus16_r | ~drop_pend_r);

  // register writes
  wire [31:0] wr_val = bus16_r ? 32'h0000_0000 : acc_data_r;
  wire [31:0] swap_wr = bus16_r ?
    merge16(swap_r, acc_data_r[15:0], half_hi) : wr_val;
  wire [31:0] tcfg_wr = bus16_r ?
    merge16(tcfg_word, acc_data_r[15:0], half_hi) : wr_val;
  wire tcfg_we = wr_go & sel_tcfg;
  wire tmr_en_nxt = tcfg_we ? tcfg_wr[TMR_EN_BIT] : tmr_en_r;
  wire tmr_fall = tmr_en_r & ~tmr_en_nxt;

  // drop counter: a drop in the clearing cycle lands after the clear
  wire [31:0] drop_inc = {31'h0000_0000, frame_drop_i};
  wire [31:0] drop_nxt = drop_clr ? drop_inc : drop_r + drop_inc;

  hcw_free_counter #(.DIV(FR_DIV)) u_free (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .count_o(free_cnt)
  );

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= HS_IDLE;
      acc_addr_r <= 8'h00;
      acc_data_r <= 32'h0000_0000;
      data_r <= 32'h0000_0000;
      oe_r <= 1'b0;
      swap_r <= SWAP_RST;
      tmr_en_r <= 1'b0;
      tmr_load_r <= TMR_LOAD_RST;
      tmr_cnt_r <= TMR_CNT_RST;
      fr_snap_r <= 32'h0000_0000;
      fr_pend_r <= 1'b0;
      drop_snap_r <= 32'h0000_0000;
      drop_pend_r <= 1'b0;
      drop_r <= DROP_RST;
      drop_evt_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (rd_go | wr_smp)
        acc_addr_r <= pin_s3_r.addr;
      if (wr_smp)
        acc_data_r <= pin_s3_r.data;
      if (rd_go)
        data_r <= rd_out;
      oe_r <= rd_on;
      if (wr_go & sel_swap)
        swap_r <= swap_wr;
      tmr_en_r <= tmr_en_nxt;
      if (tmr_fall)
        tmr_load_r <= TMR_LOAD_RST;
      else if (tcfg_we)
        tmr_load_r <= tcfg_wr[15:0];
      if (tmr_en_r)
        tmr_cnt_r <= (tmr_cnt_r == 16'h0000) ? tmr_load_r :
                     tmr_cnt_r - 16'h0001;
      if (fr_first)
        fr_snap_r <= free_cnt;
      fr_pend_r <= fr_first | (fr_pend_r & ~fr_second);
      if (drop_first)
        drop_snap_r <= drop_r;
      drop_pend_r <= drop_first | (drop_pend_r & ~drop_second);
      drop_r <= drop_nxt;
      drop_evt_r <= (drop_r == DROP_MID_PRE) & (drop_nxt == DROP_MID);
    end
  end

  // transmit: low half goes out first, high half the next clock
  wire tx_take = tx_word_vld_i & tx_rdy_r;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_half_r <= 16'h0000;
      tx_hi_r <= 16'h0000;
      tx_vld_r <= 1'b0;
      tx_rdy_r <= 1'b1;
    end
    else if (tx_take)
    begin
      tx_half_r <= tx_word_i[15:0];
      tx_hi_r <= tx_word_i[31:16];
      tx_vld_r <= 1'b1;
      tx_rdy_r <= 1'b0;
    end
    else if (!tx_rdy_r)
    begin
      tx_half_r <= tx_hi_r;
      tx_rdy_r <= 1'b1;
    end
    else
      tx_vld_r <= 1'b0;
  end

  // receive: first half is the low word
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_lo_r <= 16'h0000;
      rx_pend_r <= 1'b0;
      rx_word_r <= 32'h0000_0000;
      rx_vld_r <= 1'b0;
    end
    else
    begin
      rx_vld_r <= rx_half_vld_i & rx_pend_r;
      if (rx_half_vld_i)
        rx_pend_r <= ~rx_pend_r;
      if (rx_half_vld_i & ~rx_pend_r)
        rx_lo_r <= rx_half_i;
      if (rx_half_vld_i & rx_pend_r)
        rx_word_r <= {rx_half_i, rx_lo_r};
    end
  end

  assign data_o = data_r;
  assign data_oe_o = oe_r;
  assign drop_mid_evt_o = drop_evt_r;
  assign tx_word_rdy_o = tx_rdy_r;
  assign tx_half_o = tx_half_r;
  assign tx_half_vld_o = tx_vld_r;
  assign rx_word_o = rx_word_r;
  assign rx_word_vld_o = rx_vld_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_tcnt_read: assert property (
    rd_go && sel_tcnt && !bus16_r |=> data_r == {16'h0000, $past(tmr_cnt_r)})
    else $error("timer count read wrong");
  a_tmr_halt: assert property (
    !tmr_en_r |=> $stable(tmr_cnt_r))
    else $error("timer moved while disabled");
  a_tmr_preset: assert property (
    $fell(tmr_en_r) |-> tmr_load_r == TMR_LOAD_RST)
    else $error("preload not preset on disable");
  a_tx_low_first: assert property (
    tx_take |=> tx_vld_r && tx_half_r == $past(tx_word_i[15:0])
      ##1 tx_vld_r && tx_half_r == $past(tx_word_i[31:16], 2))
    else $error("transmit half order wrong");
  a_rx_low_first: assert property (
    rx_half_vld_i && !rx_pend_r ##1 rx_half_vld_i && rx_pend_r
      |=> rx_vld_r && rx_word_r[15:0] == $past(rx_half_i, 2))
    else $error("receive half order wrong");
  a_bus32_direct: assert property (
    rd_go && sel_swap && !bus16_r |=> data_r == $past(swap_r))
    else $error("32-bit read not direct");
  a_swap_plain: assert property (
    rd_go && sel_swap && bus16_r && swap_r != SWAP_ALL_ONES
      |=> data_r[15:0] == ($past(cur_addr[1]) ? $past(swap_r[31:16])
                                             : $past(swap_r[15:0])))
    else $error("unswapped half select wrong");
  a_swap_inv: assert property (
    rd_go && sel_tcnt && bus16_r && swap_r == SWAP_ALL_ONES && !cur_addr[1]
      |=> data_r[15:0] == 16'h0000)
    else $error("swapped half select wrong");
  a_free_replay: assert property (
    fr_second |=> data_r[15:0] == ($past(half_hi) ? $past(fr_snap_r[31:16])
                                                  : $past(fr_snap_r[15:0])))
    else $error("second half not from snapshot");
  a_drop_incr: assert property (
    frame_drop_i && !drop_clr |=> drop_r == $past(drop_r) + 32'h0000_0001)
    else $error("drop not counted");
  a_drop_clear: assert property (
    drop_clr |=> drop_r == {31'h0000_0000, $past(frame_drop_i)})
    else $error("drop counter not cleared by read");
  a_drop_mid: assert property (
    drop_r == DROP_MID_PRE && frame_drop_i && !drop_clr |=> drop_mid_evt_o)
    else $error("midpoint event missing");

  c_rd16_pair: cover property (fr_first ##[1:60] fr_second);
  c_drop_mid: cover property (drop_mid_evt_o);
  c_write_swap: cover property (wr_go && sel_swap && bus16_r);
  c_tx_back: cover property (tx_take ##2 tx_take);
endmodule : hcw_bank
`default_nettype wire

//--- tb/hcw_host_model.sv
// Purpose: host cpu model driving the sram-like pins of the bank
// Assumes: strobes held long enough to pass the pin filter
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module hcw_host_model
  import hcw_pkg::*;
(
  input wire logic clk_i,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_oe_i,
  output var hcw_pins_t pins_o
);
  initial
  begin
    pins_o = {1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 32'h5a5a_a5a5};
  end

  task automatic set_bus16(input logic v);
    pins_o.bus16 = v;
  endtask : set_bus16

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output bit ok);
    int n;
    @(posedge clk_i);
    #1;
    pins_o.addr = a;
    pins_o.cs_n = 1'b0;
    pins_o.rd_n = 1'b0;
    ok = 1'b0;
    d = '0;
    // the answer is taken at the edge where the output enable is high
    for (n = 0; n < 40 && !ok; n++)
    begin
      @(posedge clk_i);
      if (rd_oe_i === 1'b1)
      begin
        d = rd_data_i;
        ok = 1'b1;
      end
    end
    #1;
    pins_o.cs_n = 1'b1;
    pins_o.rd_n = 1'b1;
    repeat (10) @(posedge clk_i);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #1;
    pins_o.addr = a;
    pins_o.data = d;
    pins_o.cs_n = 1'b0;
    pins_o.wr_n = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    pins_o.cs_n = 1'b1;
    pins_o.wr_n = 1'b1;
    pins_o.data = ~d;
    repeat (10) @(posedge clk_i);
  endtask : wr
endmodule : hcw_host_model
`default_nettype wire

//--- tb/hcw_bank_tb_top.sv
// Purpose: self-checking bench for the host counters / word swap bank
// Assumes: 200 MHz clock, reset held six cycles
// Notes: widths switch between runs by a second reset
`timescale 1ns/1ps
`default_nettype none
module hcw_bank_tb_top
  import hcw_pkg::*;
;
  logic clk_i;
  logic rst_n_i;
  hcw_pins_t pins;
  logic [31:0] data_o;
  logic data_oe_o;
  logic frame_drop_i;
  logic drop_evt;
  logic [31:0] tx_word;
  logic tx_vld;
  logic tx_rdy;
  logic [15:0] tx_half;
  logic tx_hvld;
  logic [15:0] rx_half;
  logic rx_hvld;
  logic [31:0] rx_word;
  logic rx_wvld;
  logic [31:0] a;
  logic [31:0] b;
  int err_count;
  int comparisons;

  hcw_host_model u_host (.clk_i(clk_i), .rd_data_i(data_o),
    .rd_oe_i(data_oe_o), .pins_o(pins));

  hcw_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus16_i(pins.bus16),
    .cs_n_i(pins.cs_n), .rd_n_i(pins.rd_n), .wr_n_i(pins.wr_n),
    .addr_i(pins.addr), .data_i(pins.data), .data_o(data_o),
    .data_oe_o(data_oe_o), .frame_drop_i(frame_drop_i),
    .drop_mid_evt_o(drop_evt), .tx_word_i(tx_word),
    .tx_word_vld_i(tx_vld), .tx_word_rdy_o(tx_rdy), .tx_half_o(tx_half),
    .tx_half_vld_o(tx_hvld), .rx_half_i(rx_half),
    .rx_half_vld_i(rx_hvld), .rx_word_o(rx_word),
    .rx_word_vld_o(rx_wvld));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic rd_val(input logic [7:0] ad, output logic [31:0] d);
    bit ok;
    u_host.rd(ad, d, ok);
    if (!ok)
    begin
      err_count++;
      $display("mismatch read_handshake expected 1 seen 0");
      print_verdict();
    end
  endtask : rd_val

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] d;
    rd_val(ad, d);
    cmp($sformatf("reg_%h", ad), e, d);
  endtask : rd_chk

  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    // host allows the free counter time to clear
    repeat (FREE_CLR_CYC) @(posedge clk_i);
  endtask : do_reset

  task automatic drops(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      frame_drop_i = 1'b1;
      @(posedge clk_i);
      #1;
      frame_drop_i = 1'b0;
    end
    cmp("drop_event", 32'h0000_0000, {31'h0, drop_evt});
  endtask : drops

  task automatic tx_chk(input logic [31:0] w);
    @(posedge clk_i);
    #1;
    tx_word = w;
    tx_vld = 1'b1;
    @(posedge clk_i);
    #1;
    tx_vld = 1'b0;
    tx_word = ~w;
    cmp("tx_low", {16'h0001, w[15:0]},
        {14'h0000, tx_rdy, tx_hvld, tx_half});
    @(posedge clk_i);
    #1;
    cmp("tx_high", {16'h0003, w[31:16]},
        {14'h0000, tx_rdy, tx_hvld, tx_half});
  endtask : tx_chk

  task automatic rx_chk(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge clk_i);
    #1;
    rx_half = lo;
    rx_hvld = 1'b1;
    @(posedge clk_i);
    #1;
    rx_half = hi;
    @(posedge clk_i);
    #1;
    rx_hvld = 1'b0;
    rx_half = ~hi;
    cmp("rx_word", {hi, lo}, rx_word);
    cmp("rx_valid", 32'h0000_0001, {31'h0, rx_wvld});
  endtask : rx_chk

  initial
  begin
    err_count = 0;
    comparisons = 0;
    frame_drop_i = 1'b0;
    tx_word = 32'h0000_0000;
    tx_vld = 1'b0;
    rx_half = 16'h0000;
    rx_hvld = 1'b0;
    do_reset();
    rd_chk(OFS_TMR_CNT, {16'h0000, TMR_CNT_RST});
    rd_chk(OFS_SWAP, SWAP_RST);
    rd_chk(OFS_DROP, DROP_RST);
    rd_chk(8'hB0, 32'h0000_0000);
    u_host.wr(OFS_TMR_CNT, 32'h0000_1234);
    rd_chk(OFS_TMR_CNT, {16'h0000, TMR_CNT_RST});
    rd_val(OFS_FREE, a);
    repeat (800) @(posedge clk_i);
    rd_val(OFS_FREE, b);
    cmp("free_start", 32'h1, {31'h0, a < 64});
    cmp("free_rate", 32'h1, {31'h0, (b - a) inside {[100:105]}});
    u_host.wr(OFS_SWAP, SWAP_ALL_ONES);
    rd_chk(OFS_SWAP, SWAP_ALL_ONES);
    rd_chk(OFS_TMR_CNT, {16'h0000, TMR_CNT_RST});
    u_host.wr(OFS_SWAP, SWAP_RST);
    u_host.wr(OFS_TMR_CFG, 32'h2000_0100);
    rd_val(OFS_TMR_CNT, a);
    rd_val(OFS_TMR_CNT, b);
    cmp("tmr_runs", 32'h1, {31'h0, a !== b});
    u_host.wr(OFS_TMR_CFG, 32'h0000_0100);
    rd_chk(OFS_TMR_CFG, {16'h0000, TMR_LOAD_RST});
    rd_val(OFS_TMR_CNT, a);
    rd_chk(OFS_TMR_CNT, a);
    drops(3);
    rd_chk(OFS_DROP, 32'h0000_0003);
    rd_chk(OFS_DROP, DROP_RST);
    tx_chk(32'hA1B2_C3D4);
    tx_chk(32'h5E6F_7081);
    rx_chk(16'h1111, 16'h2222);
    u_host.set_bus16(1'b1);
    do_reset();
    rd_chk(OFS_TMR_CNT, {16'h0000, TMR_CNT_RST});
    rd_chk(OFS_TMR_CNT | 8'h02, 32'h0000_0000);
    u_host.wr(OFS_SWAP, 32'h0000_FFFF);
    u_host.wr(OFS_SWAP | 8'h02, 32'h0000_FFFF);
    rd_chk(OFS_TMR_CNT, 32'h0000_0000);
    rd_chk(OFS_TMR_CNT | 8'h02, {16'h0000, TMR_CNT_RST});
    u_host.wr(OFS_SWAP | 8'h02, 32'h0000_0000);
    rd_chk(OFS_SWAP | 8'h02, 32'h0000_FFFF);
    rd_val(OFS_FREE, a);
    rd_val(OFS_FREE, b);
    cmp("free_latch", a, b);
    drops(5);
    rd_chk(OFS_DROP, 32'h0000_0005);
    drops(2);
    rd_chk(OFS_DROP | 8'h02, 32'h0000_0000);
    rd_chk(OFS_DROP, 32'h0000_0002);
    print_verdict();
  end
endmodule : hcw_bank_tb_top
`default_nettype wire
